// File: rocs_ctrl_regs.v
// rtc oscillator control and status registers with avalon-mm slave
// Functional notes
// [RL1] oscillator field 010 runs the oscillator and the divider chain.
// [RL2] field 011 acts as 010 and makes the event-status register writable.
// [RL3] field 11x runs the oscillator and holds the divider off.
// [RL4] every other field value stops the oscillator.
// [RL5] while power fail is shown, clock and storage writes are blocked.
// [RL6] protection lasts a recovery delay after power fail clears.
// [RL7] the four control/status registers are accessible at any time, update or not.
// [RL8] rate register holds rate select 3:0, oscillator control 6:4 and read-only update-in-progress in bit 7.
// [RL9] control register holds eight read/write control bits.
// [RL10] event-status register is read-only with interrupt, periodic, alarm, update and 32 khz bits.
// [RL11] integrity register is read-only with valid backup in bit 7, zeros below.
// [RL12] reset clears oscillator bits 5:4, the four enables and all event bits, others unaffected.
// [RL13] update-ended flag is set at the end of each update cycle.
// [RL14] alarm flag is set in an update cycle when time matches the alarm bytes or they are don't-care.
// [RL15] protected writes are silently dropped.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "rocs_defs.vh"

module rocs_ctrl_regs #(
	parameter RECOV_CYC = (`ROCS_RECOV_NS + `ROCS_CLK_NS - 1) / `ROCS_CLK_NS
) (
	input  wire                     i_sys_clk,
	input  wire                     i_rst_n,
	input  wire [`ROCS_ADDR_W-1:0]  i_avs_address,
	input  wire                     i_avs_read,
	input  wire                     i_avs_write,
	input  wire [7:0]               i_avs_writedata,
	output reg  [7:0]               o_avs_readdata,
	output wire                     o_avs_waitrequest,
	input  wire                     i_power_fail,
	input  wire                     i_update_in_progress,
	input  wire                     i_update_done,
	input  wire                     i_periodic_tick,
	input  wire [7:0]               i_hours,
	input  wire [7:0]               i_minutes,
	input  wire [7:0]               i_seconds,
	input  wire [7:0]               i_alarm_hours,
	input  wire [7:0]               i_alarm_minutes,
	input  wire [7:0]               i_alarm_seconds,
	input  wire                     i_valid_backup_indication,
	output wire                     o_osc_enable,
	output wire                     o_divider_enable,
	output wire [3:0]               o_rate_select,
	output wire [7:0]               o_ctrl,
	output wire                     o_khz32_output_enable,
	output wire                     o_write_protect,
	output wire                     o_irq
);

	// ****************************************
	// functions
	// ****************************************
	function addr_is;
		input [`ROCS_ADDR_W-1:0] a_v;
		input [`ROCS_ADDR_W-1:0] off_v;
		begin
			addr_is = (a_v == off_v);
		end
	endfunction

	function alarm_hit;
		input [7:0] now_v;
		input [7:0] alm_v;
		begin
			alarm_hit = (alm_v[7:6] == `ROCS_DONT_CARE) || (alm_v == now_v);
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	reg  [1:0]            osc_low_reg;
	reg                   osc_top_reg;
	reg  [3:0]            rate_sel_reg;
	reg                   uip_reg;
	reg  [3:0]            ctrl_en_reg;
	reg                   ctrl_uti_reg;
	reg  [2:0]            ctrl_fmt_reg;
	wire [7:0]            rate_val;
	wire [7:0]            ctrl_val;
	wire                  wr_rate;
	wire                  wr_ctrl;
	wire                  wr_event;
	wire                  rd_event;
	wire                  rd_irq;
	wire                  wr_mask;
	reg  [7:0]            event_reg;
	reg  [7:0]            event_next;
	reg  [`ROCS_IRQ_W-1:0] irq_stat_reg;
	reg  [`ROCS_IRQ_W-1:0] irq_stat_next;
	reg  [`ROCS_IRQ_W-1:0] irq_mask_reg;
	reg                   ack_reg;
	reg                   pf_d_reg;
	wire                  wp;
	wire                  req;
	wire                  wr_go;
	wire                  rd_go;
	wire [2:0]            osc;
	wire                  alarm_match;
	wire                  ev_wr_ok;

	rocs_wp_timer #(
		.RECOV_CYC (RECOV_CYC)
	) u_wp (
		.i_sys_clk    (i_sys_clk),
		.i_rst_n      (i_rst_n),
		.i_power_fail (i_power_fail),
		.o_protect    (wp)
	);

	// ****************************************
	// bus handshake
	// ****************************************
	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_reg;
	assign wr_go             = i_avs_write & ack_reg;
	assign rd_go             = i_avs_read & ~ack_reg;

	// ****************************************
	// address decode strobes
	// ****************************************
	assign wr_rate  = wr_go && !wp && addr_is(i_avs_address, `ROCS_OFF_RATE); // RL5
	assign wr_ctrl  = wr_go && !wp && addr_is(i_avs_address, `ROCS_OFF_CTRL); // RL5
	assign wr_event = wr_go && !wp && ev_wr_ok && addr_is(i_avs_address, `ROCS_OFF_EVENT); // RL2
	assign rd_event = rd_go && addr_is(i_avs_address, `ROCS_OFF_EVENT);
	assign rd_irq   = rd_go && addr_is(i_avs_address, `ROCS_OFF_IRQ_STAT);
	assign wr_mask  = wr_go && addr_is(i_avs_address, `ROCS_OFF_IRQ_MASK);

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg; // RL7
		end
	end

	// ****************************************
	// oscillator decode
	// ****************************************
	assign osc              = rate_val[`ROCS_OSC_HI:`ROCS_OSC_LO];
	assign o_divider_enable = (osc == `ROCS_OSC_RUN) || (osc == `ROCS_OSC_RUN_WR); // RL1 RL2
	assign o_osc_enable     = o_divider_enable || (osc[2:1] == `ROCS_OSC_HOLD_HI); // RL3 RL4
	assign ev_wr_ok         = (osc == `ROCS_OSC_RUN_WR); // RL2
	assign o_rate_select    = rate_val[3:0];
	assign o_ctrl           = ctrl_val;
	assign o_khz32_output_enable = event_reg[`ROCS_EV_K32];
	assign o_write_protect  = wp;

	// ****************************************
	// rate and control registers
	// ****************************************
	// reset affects only the listed bits; others keep their contents
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			osc_low_reg <= 2'h0; // RL12
		end else if (wr_rate) begin // RL15
			osc_low_reg <= i_avs_writedata[`ROCS_OSC_HI-1:`ROCS_OSC_LO]; // RL8
		end
	end

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_en_reg <= 4'h0; // RL12
		end else if (wr_ctrl) begin // RL15
			ctrl_en_reg <= i_avs_writedata[6:3]; // RL9
		end
	end

	always @(posedge i_sys_clk) begin
		if (wr_rate) begin // RL15
			osc_top_reg  <= i_avs_writedata[`ROCS_OSC_HI]; // RL8
			rate_sel_reg <= i_avs_writedata[3:0];
		end
	end

	always @(posedge i_sys_clk) begin
		if (wr_ctrl) begin // RL15
			ctrl_uti_reg <= i_avs_writedata[`ROCS_CTRL_UTI]; // RL9
			ctrl_fmt_reg <= i_avs_writedata[2:0];
		end
	end

	always @(posedge i_sys_clk) begin
		uip_reg <= i_update_in_progress & ~ctrl_uti_reg; // RL8
	end

	assign rate_val = {uip_reg, osc_top_reg, osc_low_reg, rate_sel_reg};
	assign ctrl_val = {ctrl_uti_reg, ctrl_en_reg, ctrl_fmt_reg};

	// ****************************************
	// event status
	// ****************************************
	assign alarm_match = alarm_hit(i_hours, i_alarm_hours) &&
		alarm_hit(i_minutes, i_alarm_minutes) &&
		alarm_hit(i_seconds, i_alarm_seconds);

	always @* begin
		event_next = event_reg;
		if (wr_event) begin
			event_next = i_avs_writedata; // RL2
		end else if (rd_event) begin
			event_next = event_reg & ~`ROCS_EV_FLAGS;
		end
		if (i_update_done) begin
			event_next[`ROCS_EV_UPD] = 1'b1; // RL13
			if (alarm_match) begin
				event_next[`ROCS_EV_ALM] = 1'b1; // RL14
			end
		end
		if (i_periodic_tick) begin
			event_next[`ROCS_EV_PER] = 1'b1;
		end
		event_next[`ROCS_EV_ANY] = (event_next[`ROCS_EV_PER] & ctrl_val[`ROCS_CTRL_PIE]) |
			(event_next[`ROCS_EV_ALM] & ctrl_val[`ROCS_CTRL_AIE]) |
			(event_next[`ROCS_EV_UPD] & ctrl_val[`ROCS_CTRL_UIE]); // RL10
		event_next[3] = 1'b0;
		event_next[1:0] = 2'h0;
	end

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			event_reg <= 8'h00; // RL12
		end else begin
			event_reg <= event_next;
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	always @* begin
		irq_stat_next = irq_stat_reg;
		if (rd_irq) begin
			irq_stat_next = {`ROCS_IRQ_W{1'b0}};
		end
		if (i_update_done) begin
			irq_stat_next[`ROCS_IRQ_UPD] = 1'b1;
		end
		if (i_update_done && alarm_match) begin
			irq_stat_next[`ROCS_IRQ_ALM] = 1'b1;
		end
		if (i_periodic_tick) begin
			irq_stat_next[`ROCS_IRQ_PER] = 1'b1;
		end
		if (i_power_fail && !pf_d_reg) begin
			irq_stat_next[`ROCS_IRQ_PF] = 1'b1;
		end
	end

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_reg <= {`ROCS_IRQ_W{1'b0}};
			irq_mask_reg <= {`ROCS_IRQ_W{1'b0}};
			pf_d_reg     <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			pf_d_reg     <= i_power_fail;
			if (wr_mask) begin
				irq_mask_reg <= i_avs_writedata[`ROCS_IRQ_W-1:0];
			end
		end
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// ****************************************
	// read data
	// ****************************************
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_readdata <= 8'h00;
		end else if (rd_go) begin
			case (i_avs_address)
				`ROCS_OFF_RATE: begin
					o_avs_readdata <= rate_val; // RL7 RL8
				end
				`ROCS_OFF_CTRL: begin
					o_avs_readdata <= ctrl_val; // RL9
				end
				`ROCS_OFF_EVENT: begin
					o_avs_readdata <= event_reg; // RL10
				end
				`ROCS_OFF_INTEG: begin
					o_avs_readdata <= {i_valid_backup_indication, 7'h00}; // RL11
				end
				`ROCS_OFF_IRQ_STAT: begin
					o_avs_readdata <= {{(8-`ROCS_IRQ_W){1'b0}}, irq_stat_reg};
				end
				`ROCS_OFF_IRQ_MASK: begin
					o_avs_readdata <= {{(8-`ROCS_IRQ_W){1'b0}}, irq_mask_reg};
				end
				default: begin
					o_avs_readdata <= 8'h00;
				end
			endcase
		end
	end

endmodule

// File: rocs_defs.vh
// constants for the rtc oscillator control and status register block
`ifndef ROCS_DEFS_VH
`define ROCS_DEFS_VH

`define ROCS_ADDR_W        4
`define ROCS_OFF_RATE      4'ha
`define ROCS_OFF_CTRL      4'hb
`define ROCS_OFF_EVENT     4'hc
`define ROCS_OFF_INTEG     4'hd
`define ROCS_OFF_IRQ_STAT  4'he
`define ROCS_OFF_IRQ_MASK  4'hf

`define ROCS_OSC_LO        4
`define ROCS_OSC_HI        6
`define ROCS_OSC_RUN       3'h2
`define ROCS_OSC_RUN_WR    3'h3
`define ROCS_OSC_HOLD_HI   2'h3
`define ROCS_UIP_BIT       7

`define ROCS_CTRL_RST_MASK 8'h78
`define ROCS_RATE_RST_MASK 8'h30

`define ROCS_EV_ANY        7
`define ROCS_EV_PER        6
`define ROCS_EV_ALM        5
`define ROCS_EV_UPD        4
`define ROCS_EV_K32        2
`define ROCS_EV_FLAGS      8'h70

`define ROCS_CTRL_PIE      6
`define ROCS_CTRL_AIE      5
`define ROCS_CTRL_UIE      4
`define ROCS_CTRL_UTI      7

`define ROCS_VRT_BIT       7
`define ROCS_DONT_CARE     2'h3

`define ROCS_IRQ_W         4
`define ROCS_IRQ_UPD       0
`define ROCS_IRQ_ALM       1
`define ROCS_IRQ_PER       2
`define ROCS_IRQ_PF        3

`define ROCS_RECOV_NS      1000
`define ROCS_CLK_NS        5

`endif

// File: rocs_wp_timer.v
// power-fail write protection with recovery delay
`timescale 1ns/100ps
`include "rocs_defs.vh"

module rocs_wp_timer #(
	parameter RECOV_CYC = (`ROCS_RECOV_NS + `ROCS_CLK_NS - 1) / `ROCS_CLK_NS,
	parameter CNT_W     = 16
) (
	input  wire i_sys_clk,
	input  wire i_rst_n,
	input  wire i_power_fail,
	output wire o_protect
);

	reg [CNT_W-1:0] cnt_reg;
	reg [CNT_W-1:0] cnt_next;

	always @* begin
		cnt_next = cnt_reg;
		if (i_power_fail) begin
			cnt_next = RECOV_CYC[CNT_W-1:0]; // RL5
		end else if (cnt_reg != {CNT_W{1'b0}}) begin
			cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1}; // RL6
		end
	end

	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= {CNT_W{1'b0}};
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign o_protect = i_power_fail | (cnt_reg != {CNT_W{1'b0}}); // RL5 RL6

endmodule

// File: rocs_checker.sv
// port assertions for the rtc control and status registers
`timescale 1ns/100ps
module rocs_checker #(
	parameter RECOV_CYC = 4
) (
	input wire       i_sys_clk,
	input wire       i_rst_n,
	input wire [3:0] i_avs_address,
	input wire       i_avs_read,
	input wire       i_avs_write,
	input wire [7:0] i_avs_writedata,
	input wire       o_avs_waitrequest,
	input wire       i_power_fail,
	input wire       o_osc_enable,
	input wire       o_divider_enable,
	input wire [3:0] o_rate_select,
	input wire [7:0] o_ctrl,
	input wire       o_khz32_output_enable,
	input wire       o_write_protect,
	input wire       o_irq
);
// ****
// properties
// ****
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_rst_n);
wire wdone = i_avs_write && !o_avs_waitrequest;
property p_div; o_divider_enable |-> o_osc_enable; endproperty
a_div: assert property (p_div) else $error("divider without osc");
property p_pf; i_power_fail |-> o_write_protect; endproperty
a_pf: assert property (p_pf) else $error("no protect in power fail");
property p_hold; $fell(i_power_fail) |=> o_write_protect[*3]; endproperty
a_hold: assert property (p_hold) else $error("recovery too short");
property p_end; $fell(i_power_fail) |-> ##[1:12] (!o_write_protect || i_power_fail); endproperty
a_end: assert property (p_end) else $error("recovery too long");
property p_wait; $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
a_wait: assert property (p_wait) else $error("bad wait cycle");
property p_wr; wdone && !o_write_protect && i_avs_address == 4'hb |=> o_ctrl == $past(i_avs_writedata); endproperty
a_wr: assert property (p_wr) else $error("control write lost");
property p_drop; wdone && o_write_protect |=> $stable(o_ctrl) && $stable(o_rate_select); endproperty
a_drop: assert property (p_drop) else $error("protected write landed");
property p_k32; $changed(o_khz32_output_enable) |-> $past(wdone && i_avs_address == 4'hc); endproperty
a_k32: assert property (p_k32) else $error("32k enable moved alone");
property p_rst; $rose(i_rst_n) |-> o_ctrl[6:3] == 4'h0 && !o_irq; endproperty
a_rst: assert property (p_rst) else $error("reset state wrong");
c_prot: cover property (wdone && o_write_protect);
c_irq: cover property ($rose(o_irq));
c_k32: cover property ($rose(o_khz32_output_enable));
endmodule

// File: tb_top.sv
// self-checking testbench for the rtc control and status registers
`timescale 1ns/100ps
module tb_top;
// ****
// signals and design
// ****
localparam RC = 4;
reg        clk = 0;
reg        rst_n = 0;
reg  [3:0] adr = 0;
reg        rd = 0, wr = 0, pf = 0, update_in_progress = 0, upd = 0, tick = 0;
reg  [7:0] wd = 0, hh = 0, mm = 0, ss = 0, ahr = 0, amn = 0, asc = 0, v;
wire [7:0] rdat, ctrl;
wire [3:0] rsel;
wire       wq, osc, div, k32, wp, irq;
integer    error_cnt = 0, n_tests = 0, f;
rocs_ctrl_regs #(.RECOV_CYC(RC)) i_rocs_ctrl_regs (
	.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
	.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
	.i_power_fail(pf), .i_update_in_progress(update_in_progress), .i_update_done(upd), .i_periodic_tick(tick),
	.i_hours(hh), .i_minutes(mm), .i_seconds(ss), .i_alarm_hours(ahr), .i_alarm_minutes(amn),
	.i_alarm_seconds(asc), .i_valid_backup_indication(1'b1), .o_osc_enable(osc),
	.o_divider_enable(div), .o_rate_select(rsel), .o_ctrl(ctrl), .o_khz32_output_enable(k32),
	.o_write_protect(wp), .o_irq(irq));
initial forever #2.5 clk = ~clk;
// ****
// tasks
// ****
task chk(input [7:0] s, input [7:0] e);
	begin
		n_tests = n_tests + 1;
		if (s !== e) begin
			error_cnt = error_cnt + 1;
			$display("mismatch at %0t: %h expected %h", $time, s, e);
		end
	end
endtask
task acc(input [3:0] a, input w, input [7:0] d);
	reg b;
	begin
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		b = 1;
		while (b) begin
			@(posedge clk);
			b = (wq !== 1'b0);
			v = rdat;
		end
		wr <= 0;
		rd <= 0;
		@(posedge clk);
	end
endtask
task pulse(input u, input p);
	begin
		@(posedge clk);
		upd <= u;
		tick <= p;
		@(posedge clk);
		upd <= 0;
		tick <= 0;
		@(posedge clk);
	end
endtask
task t_osc;
	begin
		acc(4'hb, 1, 8'h00);
		for (f = 0; f < 8; f = f + 1) begin
			update_in_progress <= f[0];
			acc(4'ha, 1, {~f[0], f[2:0], f[3:0]});
			chk({7'h0, osc}, {7'h0, f > 1 && f != 4 && f != 5});
			chk({7'h0, div}, {7'h0, f == 2 || f == 3});
			chk({4'h0, rsel}, f[7:0]);
			acc(4'ha, 0, 0);
			chk(v, {f[0], f[2:0], f[3:0]});
		end
	end
endtask
task t_ctrl;
	begin
		acc(4'hb, 1, 8'ha5);
		acc(4'hb, 0, 0);
		chk(v, 8'ha5);
		acc(4'ha, 0, 0);
		chk(v & 8'h80, 8'h00);
		acc(4'hd, 1, 8'h00);
		acc(4'hd, 0, 0);
		chk(v, 8'h80);
		acc(4'h3, 1, 8'hff);
		acc(4'h3, 0, 0);
		chk(v, 8'h00);
		acc(4'hb, 1, 8'h00);
	end
endtask
task t_event;
	begin
		acc(4'ha, 1, 8'h20);
		acc(4'hc, 1, 8'h04);
		chk({7'h0, k32}, 8'h00);
		acc(4'ha, 1, 8'h30);
		acc(4'hc, 1, 8'h04);
		chk({7'h0, k32}, 8'h01);
		acc(4'hf, 1, 8'h01);
		hh <= 8'h12;
		mm <= 8'h34;
		ss <= 8'h56;
		ahr <= 8'hc0;
		amn <= 8'h34;
		asc <= 8'h56;
		pulse(1, 0);
		chk({7'h0, irq}, 8'h01);
		acc(4'he, 0, 0);
		chk(v, 8'h03);
		acc(4'hc, 0, 0);
		chk(v, 8'h34);
		chk({7'h0, irq}, 8'h00);
		acc(4'hf, 1, 8'h00);
		acc(4'hb, 1, 8'h10);
		ahr <= 8'h11;
		pulse(1, 1);
		chk({7'h0, irq}, 8'h00);
		acc(4'hc, 0, 0);
		chk(v, 8'hd4);
		acc(4'hb, 1, 8'h00);
	end
endtask
task t_wp;
	begin
		pf <= 1;
		acc(4'hb, 1, 8'h0f);
		acc(4'hb, 0, 0);
		chk(v, 8'h00);
		pf <= 0;
		acc(4'hb, 1, 8'h0f);
		acc(4'hb, 0, 0);
		chk(v, 8'h00);
		repeat (RC) @(posedge clk);
		acc(4'hb, 1, 8'h0f);
		acc(4'hb, 0, 0);
		chk(v, 8'h0f);
		acc(4'he, 0, 0);
		chk(v & 8'h08, 8'h08);
	end
endtask
task report_and_stop;
	begin
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	end
endtask
// ****
// sequence
// ****
initial begin
	repeat (2) @(posedge clk);
	rst_n <= 1;
	acc(4'hc, 0, 0);
	chk(v, 8'h00);
	chk(ctrl & 8'h78, 8'h00);
	t_osc;
	t_ctrl;
	t_event;
	t_wp;
	report_and_stop;
end
initial begin
	#20000;
	error_cnt = error_cnt + 1;
	report_and_stop;
end
endmodule
bind rocs_ctrl_regs rocs_checker #(.RECOV_CYC(RECOV_CYC)) i_rocs_checker (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_power_fail(i_power_fail), .o_osc_enable(o_osc_enable),
	.o_divider_enable(o_divider_enable), .o_rate_select(o_rate_select), .o_ctrl(o_ctrl),
	.o_khz32_output_enable(o_khz32_output_enable), .o_write_protect(o_write_protect), .o_irq(o_irq));
